// File: core/dsw_pkg.sv
/*
 Constants, states and carrier structs for the drive status word block.
 Assumes one 25 MHz clock and that all inputs are synchronous to it.
*/
package dsw_pkg;
   localparam int unsigned SW_W = 16;
   // Status word bit positions
   localparam int unsigned B_CTRL_RDY = 0;
   localparam int unsigned B_DRV_RDY = 1;
   localparam int unsigned B_ENABLE = 2;
   localparam int unsigned B_TRIP = 3;
   localparam int unsigned B_ERR = 4;
   localparam int unsigned B_RESV = 5;
   localparam int unsigned B_LOCK = 6;
   localparam int unsigned B_WARN = 7;
   localparam int unsigned B_AT_REF = 8;
   localparam int unsigned B_BUS_CTL = 9;
   localparam int unsigned B_FLIM_OK = 10;
   localparam int unsigned B_IN_OP = 11;
   localparam int unsigned B_OT_STOP = 12;
   localparam int unsigned B_VOLT = 13;
   localparam int unsigned B_TORQUE = 14;
   localparam int unsigned B_TIMER = 15;
   localparam logic [15:0] SW_RESET = 16'h0000;
   localparam logic [15:0] ZERO16 = 16'h0000;
   // Relative word scaling, 16384 is full scale
   localparam logic [15:0] REL_FULL16 = 16'h4000;
   localparam logic signed [31:0] REL_FULL32 = 32'sh0000_4000;
   localparam logic signed [31:0] REL_MAX = 32'sh0000_7fff;
   localparam logic signed [31:0] REL_MIN = 32'shffff_8000;
   localparam int unsigned REL_SHIFT = 14;
   // Indication flash half period
   localparam int unsigned CLK_HZ = 25000000;
   localparam int unsigned FLASH_MS = 250;
   localparam int unsigned FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_TRIP = 2'b01,
      ST_LOCK = 2'b10,
      ST_WAIT_ON = 2'b11
   } dsw_state_e;

   typedef struct packed {
      logic ctrl_ready;
      logic drive_ready;
      logic coast_cmd;
      logic err_no_trip;
      logic start_sig;
      logic overtemp_stop;
      logic dc_low;
      logic dc_high;
      logic panel_stop;
      logic local_site;
      logic link_lost;
      logic comm_fault;
   } dsw_drv_s;

   typedef struct packed {
      logic fault;
      logic lock;
      logic reset_panel;
      logic reset_di;
      logic auto_reset_en;
      logic auto_on_key;
   } dsw_alarm_s;
endpackage

// File: core/dsw_rise.sv
/*
 Rising transition detector for a level control bit.
 Assumes the input is synchronous to CLK; frozen while ce is low.
*/
`timescale 1ns/1ps
module dsw_rise (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic lvl,
   output logic rise
);
   import dsw_pkg::*;

   typedef struct packed {
      logic prev;
   } dsw_rise_s;

   dsw_rise_s r_ff;
   dsw_rise_s nxt_r;

   always_comb begin
      nxt_r = r_ff;
      nxt_r.prev = lvl;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r_ff <= '0;
      end else if (ce) begin
         r_ff <= nxt_r;
      end
   end

   assign rise = ce & lvl & ~r_ff.prev;
endmodule // dsw_rise

// File: core/dsw_scale.sv
/*
 Converts between raw signed values and 16-bit relative words.
 Assumes FULL_SCALE raw units equal 16384 relative units.
*/
`timescale 1ns/1ps
module dsw_scale #(
   parameter int FULL_SCALE = 500,
   parameter bit TO_REL = 1'b1
) (
   input wire logic signed [15:0] in_val,
   output logic signed [15:0] out_val
);
   import dsw_pkg::*;

   localparam logic signed [31:0] FULL_W = 32'(FULL_SCALE);

   logic signed [31:0] wide;
   logic signed [31:0] prod;

   always_comb begin
      wide = 32'(in_val);
      if (TO_REL) begin
         prod = wide * REL_FULL32 / FULL_W;
      end else begin
         prod = (wide * FULL_W) >>> REL_SHIFT;
      end
      if (prod > REL_MAX) begin
         out_val = REL_MAX[15:0];
      end else if (prod < REL_MIN) begin
         out_val = REL_MIN[15:0];
      end else begin
         out_val = prod[15:0];
      end
   end
endmodule // dsw_scale

// File: core/dsw_core.sv
/*
 Drive status word, relative word scaling and alarm state handling.
 Assumes synchronous inputs, power cycle equals RST_B, CE freezes all.
*/
// Summary of operation
// - Bit 00 control ready, cleared on trip
// - Bit 01 drive ready, even while coasting
// - Bit 02 low while motor released
// - Bit 03 trip, held until reset
// - Bit 04 error without trip
// - Bit 05 reserved, no function
// - Bit 06 tripped and locked
// - Bit 07 any warning present
// - Bit 08 speed equals reference
// - Bit 09 bus control possible
// - Bit 10 frequency inside limits
// - Bit 11 start signal or frequency nonzero
// - Bit 12 overtemperature stop, auto resume
// - Bit 13 DC voltage out of range
// - Bit 14 torque or current limit exceeded
// - Bit 15 a thermal timer above full
// - Whole word zero on link loss
// - Relative words, 16384 is full scale
// - Warning follows its cause only
// - Trip held until reset after cure
// - Panel reset waits for auto-on key
// - Lock needs power cycle, no auto reset
// - Coast, flash alarm and warning indications
// - Bus reset acts on rising edge
`timescale 1ns/1ps
module dsw_core #(
   parameter int FULL_SCALE = 500,
   parameter int N_WARN = 8,
   parameter int unsigned FLASH_CYCLES = dsw_pkg::FLASH_CYC
) (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic CE,
   input wire dsw_pkg::dsw_drv_s DRV,
   input wire dsw_pkg::dsw_alarm_s ALM,
   input wire logic [N_WARN-1:0] WARN_CAUSE,
   input wire logic CTRL_RESET_BIT,
   input wire logic signed [15:0] BUS_REF,
   input wire logic signed [15:0] ACT_FREQ,
   input wire logic [15:0] LOW_LIM,
   input wire logic [15:0] HIGH_LIM,
   input wire logic [15:0] CURRENT,
   input wire logic [15:0] CURRENT_LIM,
   input wire logic [15:0] MOTOR_TMR,
   input wire logic [15:0] DRIVE_TMR,
   output logic [15:0] STATUS_WORD,
   output logic signed [15:0] ACT_VALUE,
   output logic signed [15:0] REF_FREQ,
   output logic MOTOR_COAST,
   output logic ALARM_LED,
   output logic WARN_LED
);
   import dsw_pkg::*;

   localparam int CNT_W = $clog2(FLASH_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FLASH_CYCLES - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO = '0;

   typedef struct packed {
      dsw_state_e st;
      logic [15:0] sw;
      logic signed [15:0] act;
      logic signed [15:0] ref_f;
      logic coast;
      logic aled;
      logic wled;
      logic [CNT_W-1:0] cnt;
      logic phase;
   } dsw_core_s;

   dsw_core_s r_ff;
   dsw_core_s nxt_r;

   logic bus_rst_edge;
   logic signed [15:0] act_rel;
   logic signed [15:0] ref_raw;
   logic rst_evt;
   logic warn_any;
   logic [15:0] f_mag;
   logic [15:0] w;

   function automatic logic is_trip(input dsw_state_e s);
      is_trip = (s == ST_TRIP) || (s == ST_LOCK);
   endfunction

   function automatic logic [15:0] mag16(input logic signed [15:0] v);
      mag16 = v[15] ? (~v + 16'h0001) : v;
   endfunction

   // Bus reset on leading edge only
   dsw_rise u_rise (
      .clk(CLK),
      .rst_b(RST_B),
      .ce(CE),
      .lvl(CTRL_RESET_BIT),
      .rise(bus_rst_edge)
   );

   // Actual output value to relative word
   dsw_scale #(
      .FULL_SCALE(FULL_SCALE),
      .TO_REL(1'b1)
   ) u_act (
      .in_val(ACT_FREQ),
      .out_val(act_rel)
   );

   // Bus reference relative word to raw
   dsw_scale #(
      .FULL_SCALE(FULL_SCALE),
      .TO_REL(1'b0)
   ) u_ref (
      .in_val(BUS_REF),
      .out_val(ref_raw)
   );

   always_comb begin
      nxt_r = r_ff;
      w = SW_RESET;
      warn_any = |WARN_CAUSE;
      f_mag = mag16(ACT_FREQ);
      // Auto reset only from a plain trip
      rst_evt = ALM.reset_panel | ALM.reset_di | bus_rst_edge
         | (ALM.auto_reset_en & (r_ff.st == ST_TRIP));

      // Alarm state
      unique case (r_ff.st)
         ST_RUN: begin
            if (ALM.fault) begin
               nxt_r.st = ALM.lock ? ST_LOCK : ST_TRIP;
            end
         end
         ST_WAIT_ON: begin
            if (ALM.fault) begin
               nxt_r.st = ALM.lock ? ST_LOCK : ST_TRIP;
            end else if (ALM.auto_on_key) begin
               nxt_r.st = ST_RUN;
            end
         end
         ST_TRIP: begin
            if (ALM.fault && ALM.lock) begin
               nxt_r.st = ST_LOCK;
            end else if (!ALM.fault && rst_evt) begin
               nxt_r.st = ALM.reset_panel ? ST_WAIT_ON : ST_RUN;
            end
         end
         ST_LOCK: begin
            nxt_r.st = ST_LOCK;
         end
      endcase

      // Status word from the next state
      w[B_CTRL_RDY] = DRV.ctrl_ready & ~is_trip(nxt_r.st);
      w[B_DRV_RDY] = DRV.drive_ready;
      w[B_ENABLE] = ~DRV.coast_cmd & (nxt_r.st == ST_RUN);
      w[B_TRIP] = is_trip(nxt_r.st);
      w[B_ERR] = DRV.err_no_trip;
      w[B_RESV] = 1'b0;
      w[B_LOCK] = (nxt_r.st == ST_LOCK);
      w[B_WARN] = warn_any;
      w[B_AT_REF] = (ACT_FREQ == ref_raw);
      w[B_BUS_CTL] = ~DRV.panel_stop & ~DRV.local_site;
      w[B_FLIM_OK] = (f_mag > LOW_LIM) && (f_mag < HIGH_LIM);
      w[B_IN_OP] = DRV.start_sig | (ACT_FREQ != ZERO16);
      w[B_OT_STOP] = DRV.overtemp_stop;
      w[B_VOLT] = DRV.dc_low | DRV.dc_high;
      w[B_TORQUE] = CURRENT > CURRENT_LIM;
      w[B_TIMER] = (MOTOR_TMR > REL_FULL16) || (DRIVE_TMR > REL_FULL16);
      if (DRV.link_lost || DRV.comm_fault) begin
         w = ZERO16;
      end
      nxt_r.sw = w;
      nxt_r.act = act_rel;
      nxt_r.ref_f = ref_raw;

      // Flash timebase
      if (r_ff.cnt == CNT_LAST) begin
         nxt_r.cnt = CNT_ZERO;
         nxt_r.phase = ~r_ff.phase;
      end else begin
         nxt_r.cnt = r_ff.cnt + 1'b1;
      end

      // Coasting and indications
      nxt_r.coast = (nxt_r.st != ST_RUN);
      if (is_trip(nxt_r.st)) begin
         nxt_r.aled = nxt_r.phase;
         nxt_r.wled = ALM.fault & nxt_r.phase;
      end else begin
         nxt_r.aled = 1'b0;
         nxt_r.wled = warn_any;
      end
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         r_ff <= '{st: ST_RUN, default: '0};
      end else if (CE) begin
         r_ff <= nxt_r;
      end
   end

   assign STATUS_WORD = r_ff.sw;
   assign ACT_VALUE = r_ff.act;
   assign REF_FREQ = r_ff.ref_f;
   assign MOTOR_COAST = r_ff.coast;
   assign ALARM_LED = r_ff.aled;
   assign WARN_LED = r_ff.wled;

   // Checks
   logic lost;
   assign lost = DRV.link_lost | DRV.comm_fault;

   sequence s_trip_cured;
      CE && r_ff.st == ST_TRIP && !ALM.fault;
   endsequence

   sequence s_steady_bus_bit;
      CE && CTRL_RESET_BIT ##1 CE && CTRL_RESET_BIT;
   endsequence

   sequence s_bus_rise;
      CE && !CTRL_RESET_BIT ##1 CE && CTRL_RESET_BIT;
   endsequence

   link_zero_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && lost |=> STATUS_WORD == ZERO16)
      else $error("status word not cleared on link loss");

   resv_zero_a: assert property (@(posedge CLK) disable iff (!RST_B)
      STATUS_WORD[B_RESV] == 1'b0)
      else $error("reserved status bit set");

   lock_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
      r_ff.st == ST_LOCK |=> r_ff.st == ST_LOCK)
      else $error("trip lock left without power cycle");

   trip_set_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && ALM.fault && !lost |=> STATUS_WORD[B_TRIP] && STATUS_WORD[B_CTRL_RDY] == 1'b0)
      else $error("trip bit not shown for fault");

   edge_only_a: assert property (@(posedge CLK) disable iff (!RST_B)
      s_steady_bus_bit ##0 s_trip_cured ##0 (!ALM.reset_panel && !ALM.reset_di
      && !ALM.auto_reset_en) |=> r_ff.st == ST_TRIP)
      else $error("steady bus reset bit reset the trip");

   panel_wait_a: assert property (@(posedge CLK) disable iff (!RST_B)
      s_trip_cured ##0 ALM.reset_panel |=> r_ff.st == ST_WAIT_ON && MOTOR_COAST
      ##1 (!$past(CE) || $past(ALM.auto_on_key) || MOTOR_COAST))
      else $error("panel reset restarted motor without auto-on");

   di_reset_a: assert property (@(posedge CLK) disable iff (!RST_B)
      s_trip_cured ##0 ALM.reset_di && !ALM.reset_panel |=> r_ff.st == ST_RUN)
      else $error("cured trip not reset by digital input");

   warn_bit_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost |=> STATUS_WORD[B_WARN] == ($past(WARN_CAUSE) != '0))
      else $error("warning bit does not follow causes");

   bus_ctl_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost && (DRV.panel_stop || DRV.local_site) |=> !STATUS_WORD[B_BUS_CTL])
      else $error("bus control shown under local operation");

   coast_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && ALM.fault |=> MOTOR_COAST && ALARM_LED == r_ff.phase)
      else $error("coast or alarm indication wrong");

   ctrl_rdy_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost && DRV.ctrl_ready && r_ff.st == ST_RUN && !ALM.fault
      |=> STATUS_WORD[B_CTRL_RDY])
      else $error("control ready bit missing");

   drv_rdy_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost && DRV.drive_ready |=> STATUS_WORD[B_DRV_RDY])
      else $error("drive ready bit missing");

   coast_bit_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost && DRV.coast_cmd |=> !STATUS_WORD[B_ENABLE])
      else $error("enable bit shown while coasting");

   err_bit_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost |=> STATUS_WORD[B_ERR] == $past(DRV.err_no_trip))
      else $error("error bit does not follow its cause");

   lock_bit_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost && r_ff.st == ST_LOCK |=> STATUS_WORD[B_LOCK] && STATUS_WORD[B_TRIP])
      else $error("trip lock bits missing");

   no_lock_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost && !ALM.fault && r_ff.st != ST_LOCK |=> !STATUS_WORD[B_LOCK])
      else $error("lock bit without trip lock");

   at_zero_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost && BUS_REF == ZERO16 && ACT_FREQ == ZERO16 |=> STATUS_WORD[B_AT_REF])
      else $error("speed equal to reference not shown");

   off_ref_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost && BUS_REF == ZERO16 && ACT_FREQ != ZERO16 |=> !STATUS_WORD[B_AT_REF])
      else $error("speed differs but reference bit set");

   bus_ok_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost && !DRV.panel_stop && !DRV.local_site |=> STATUS_WORD[B_BUS_CTL])
      else $error("bus control not shown");

   flim_zero_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost && ACT_FREQ == ZERO16 |=> !STATUS_WORD[B_FLIM_OK])
      else $error("limit bit set at standstill");

   flim_hi_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost && !ACT_FREQ[15] && ACT_FREQ >= HIGH_LIM |=> !STATUS_WORD[B_FLIM_OK])
      else $error("limit bit set at high limit");

   in_op_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost && (DRV.start_sig || ACT_FREQ != ZERO16) |=> STATUS_WORD[B_IN_OP])
      else $error("operation bit missing");

   ot_stop_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost |=> STATUS_WORD[B_OT_STOP] == $past(DRV.overtemp_stop))
      else $error("overtemperature bit wrong");

   volt_bit_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost && (DRV.dc_low || DRV.dc_high) |=> STATUS_WORD[B_VOLT])
      else $error("voltage bit missing");

   torque_bit_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost && CURRENT <= CURRENT_LIM |=> !STATUS_WORD[B_TORQUE])
      else $error("torque bit set below limit");

   timer_bit_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && !lost && MOTOR_TMR <= REL_FULL16 && DRIVE_TMR <= REL_FULL16
      |=> !STATUS_WORD[B_TIMER])
      else $error("timer bit set below full scale");

   trip_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && r_ff.st == ST_TRIP && ALM.fault |=> is_trip(r_ff.st))
      else $error("trip left while cause present");

   bus_edge_a: assert property (@(posedge CLK) disable iff (!RST_B)
      s_bus_rise ##0 s_trip_cured ##0 !ALM.reset_panel |=> r_ff.st == ST_RUN)
      else $error("bus reset edge ignored");

   auto_reset_a: assert property (@(posedge CLK) disable iff (!RST_B)
      s_trip_cured ##0 ALM.auto_reset_en && !ALM.reset_panel |=> r_ff.st == ST_RUN)
      else $error("automatic reset ignored");

   wait_run_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && r_ff.st == ST_WAIT_ON && !ALM.fault && ALM.auto_on_key
      |=> r_ff.st == ST_RUN && !MOTOR_COAST)
      else $error("auto-on key did not restart");

   lock_led_a: assert property (@(posedge CLK) disable iff (!RST_B)
      CE && r_ff.st == ST_LOCK && !ALM.fault |=> !WARN_LED)
      else $error("warning indication after cause cleared");
endmodule // dsw_core

// File: tb/dsw_master.sv
/*
 Bus master model: sends the relative speed reference and the reset control bit.
 Assumes the bench sets its requests just after a falling clock edge.
*/
`timescale 1ns/1ps
module dsw_master (
   input wire logic rst_req,
   input wire logic signed [15:0] ref_pct,
   output logic reset_bit,
   output logic signed [15:0] bus_ref
);
   // Reference already a relative word, 16'h4000 is full scale
   assign bus_ref = ref_pct;
   // Reset bit is a level; only its rising transition acts
   assign reset_bit = rst_req;
endmodule // dsw_master

// File: tb/tb_top.sv
/*
 Testbench for the drive status word block with directed sequences.
 Assumes FULL_SCALE 500 and a flash half period of 4 cycles.
*/
`timescale 1ns/1ps
module tb_top;
   import dsw_pkg::*;
   logic CLK = 1'b0;
   logic RST_B = 1'b0;
   dsw_drv_s drv;
   dsw_alarm_s alm;
   logic [7:0] warn = 8'h00;
   logic rreq = 1'b0;
   logic ce = 1'b1;
   logic signed [15:0] rpct = 16'sh0000;
   logic signed [15:0] act = 16'sh0000;
   logic [15:0] lo = 16'h0000, hi = 16'h0000, cur = 16'h0000, clim = 16'h0064;
   logic [15:0] mtm = 16'h0000, dtm = 16'h0000;
   logic rbit, coast, aled, wled;
   logic signed [15:0] bref, aval, rfreq;
   logic [15:0] sw;
   int failures = 0;
   int checks = 0;
   logic [15:0] exp_tab [0:8] = '{16'h0000, 16'h0000, 16'h0107, 16'h0107, 16'h2307,
      16'h2307, 16'h1307, 16'h0b07, 16'h0317};

   initial forever #20 CLK = ~CLK;

   dsw_master master (.rst_req(rreq), .ref_pct(rpct), .reset_bit(rbit), .bus_ref(bref));

   dsw_core #(.FULL_SCALE(500), .N_WARN(8), .FLASH_CYCLES(4)) dut (.CLK(CLK), .RST_B(RST_B),
      .CE(ce), .DRV(drv), .ALM(alm), .WARN_CAUSE(warn), .CTRL_RESET_BIT(rbit),
      .BUS_REF(bref), .ACT_FREQ(act), .LOW_LIM(lo), .HIGH_LIM(hi), .CURRENT(cur),
      .CURRENT_LIM(clim), .MOTOR_TMR(mtm), .DRIVE_TMR(dtm), .STATUS_WORD(sw),
      .ACT_VALUE(aval), .REF_FREQ(rfreq), .MOTOR_COAST(coast), .ALARM_LED(aled),
      .WARN_LED(wled));

   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, exp, got);
      end
   endtask

   task automatic cyc();
      @(negedge CLK);
   endtask

   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask

   task automatic end_of_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic leds(input logic [15:0] ea, input logic [15:0] ew);
      int na;
      int nw;
      na = 0;
      nw = 0;
      repeat (8) begin
         cyc();
         if (aled === 1'b1) na++;
         if (wled === 1'b1) nw++;
      end
      chk("alarm_led", 16'(na), ea);
      chk("warn_led", 16'(nw), ew);
   endtask

   initial begin
      drv = dsw_drv_s'(12'hc00);
      alm = dsw_alarm_s'(6'h00);
      repeat (2) cyc();
      chk("sw_rst", sw, 16'h0000);
      RST_B = 1'b1;
      cyc();
      chk("sw_base", sw, 16'h0307);
      drv.coast_cmd = 1'b1;
      cyc();
      chk("sw_coast", sw, 16'h0303);
      drv.coast_cmd = 1'b0;
      for (int k = 0; k < 9; k++) begin
         drv = dsw_drv_s'(12'hc00 | (12'h001 << k));
         cyc();
         chk("sw_in", sw, exp_tab[k]);
      end
      drv = dsw_drv_s'(12'hc00);
      warn = 8'h80;
      cyc();
      chk("sw_warn", sw, 16'h0387);
      chk("wled", {15'h0, wled}, 16'h0001);
      warn = 8'h00;
      cyc();
      chk("sw_nowarn", sw, 16'h0307);
      ce = 1'b0;
      warn = 8'h01;
      cyc();
      chk("sw_freeze", sw, 16'h0307);
      ce = 1'b1;
      cyc();
      chk("sw_thaw", sw, 16'h0387);
      warn = 8'h00;
      cur = 16'h0065;
      cyc();
      chk("sw_cur", sw, 16'h4307);
      cur = 16'h0064;
      mtm = 16'h4000;
      cyc();
      chk("sw_lim", sw, 16'h0307);
      mtm = 16'h4001;
      cyc();
      chk("sw_mtm", sw, 16'h8307);
      mtm = 16'h0000;
      dtm = 16'h4001;
      cyc();
      chk("sw_dtm", sw, 16'h8307);
      dtm = 16'h0000;
      done("status");
      rpct = 16'sh4000;
      act = 16'sd500;
      lo = 16'h000a;
      hi = 16'h0258;
      cyc();
      chk("ref", rfreq, 16'h01f4);
      chk("act", aval, 16'h4000);
      chk("sw_atref", sw, 16'h0f07);
      act = -16'sd250;
      cyc();
      chk("act_neg", aval, 16'he000);
      chk("sw_ramp", sw, 16'h0e07);
      act = 16'sd600;
      rpct = 16'shc000;
      cyc();
      chk("act_hi", aval, 16'h4ccc);
      chk("ref_neg", rfreq, 16'hfe0c);
      chk("sw_hilim", sw, 16'h0a07);
      act = 16'sd2000;
      cyc();
      chk("act_sat", aval, 16'h7fff);
      act = 16'sh0000;
      rpct = 16'sh0000;
      lo = 16'h0000;
      hi = 16'h0000;
      cyc();
      done("scaling");
      alm.fault = 1'b1;
      cyc();
      chk("sw_trip", sw, 16'h030a);
      chk("coast", {15'h0, coast}, 16'h0001);
      leds(16'h0004, 16'h0004);
      rreq = 1'b1;
      cyc();
      alm.fault = 1'b0;
      cyc();
      chk("sw_held", sw, 16'h030a);
      leds(16'h0004, 16'h0000);
      rreq = 1'b0;
      cyc();
      rreq = 1'b1;
      cyc();
      chk("sw_busrst", sw, 16'h0307);
      chk("run", {15'h0, coast}, 16'h0000);
      rreq = 1'b0;
      alm.fault = 1'b1;
      cyc();
      alm.fault = 1'b0;
      alm.reset_panel = 1'b1;
      cyc();
      alm.reset_panel = 1'b0;
      cyc();
      chk("wait_on", {15'h0, coast}, 16'h0001);
      alm.auto_on_key = 1'b1;
      cyc();
      alm.auto_on_key = 1'b0;
      chk("sw_auto_on", sw, 16'h0307);
      alm.fault = 1'b1;
      cyc();
      alm.fault = 1'b0;
      alm.reset_di = 1'b1;
      cyc();
      alm.reset_di = 1'b0;
      chk("sw_di", sw, 16'h0307);
      alm.fault = 1'b1;
      alm.auto_reset_en = 1'b1;
      cyc();
      chk("sw_trip2", sw, 16'h030a);
      alm.fault = 1'b0;
      cyc();
      chk("sw_autorst", sw, 16'h0307);
      done("trip");
      alm = dsw_alarm_s'(6'h20);
      cyc();
      chk("sw_trip3", sw, 16'h030a);
      alm = dsw_alarm_s'(6'h30);
      cyc();
      chk("sw_lock", sw, 16'h034a);
      alm = dsw_alarm_s'(6'h1e);
      rreq = 1'b1;
      repeat (3) cyc();
      chk("sw_locked", sw, 16'h034a);
      alm = dsw_alarm_s'(6'h00);
      rreq = 1'b0;
      RST_B = 1'b0;
      cyc();
      chk("sw_pwr", sw, 16'h0000);
      RST_B = 1'b1;
      cyc();
      chk("sw_unlock", sw, 16'h0307);
      done("lock");
      end_of_test();
   end

   initial begin
      #(40 * 2000);
      failures++;
      end_of_test();
   end
endmodule // tb_top
